// ---- rpdc_top.sv ----
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rpdc_defines.svh"

module rpdc_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // RTC alarm interrupt, asynchronous
    input wire logic rtc_alarm_i,
    // AXI4-Lite write
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Supply enables
    output rpdc_pkg::rpdc_supply_t supply_o
);
    import rpdc_pkg::*;

    function automatic rpdc_sel_t rpdc_decode(input logic [15:0] addr);
        rpdc_decode = (addr == `RPDC_ADDR_PM) ? RPDC_SEL_PM :
                      (addr == `RPDC_ADDR_CTRL) ? RPDC_SEL_CTRL : RPDC_SEL_NONE;
    endfunction : rpdc_decode

    ////////////////////////////////////////////////////////////////////////////
    // Alarm synchroniser

    logic alarm_sync;

    rpdc_sync u_alarm_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(rtc_alarm_i),
        .sync_o(alarm_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    rpdc_ch_st_t wr_st_reg, wr_st_next;
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [15:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic awready_next, wready_next, bvalid_next;
    logic [1:0] bresp_next;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    assign aw_got_next = (wr_st_reg == RPDC_CH_IDLE) && (aw_got_reg || aw_fire);
    assign w_got_next = (wr_st_reg == RPDC_CH_IDLE) && (w_got_reg || w_fire);
    assign awaddr_next = aw_fire ? s_axi_awaddr : awaddr_reg;
    assign wdata_next = w_fire ? s_axi_wdata : wdata_reg;
    assign wstrb0_next = w_fire ? s_axi_wstrb[0] : wstrb0_reg;

    // Both halves in hand: commit the write this cycle
    wire wr_commit = (wr_st_reg == RPDC_CH_IDLE) && aw_got_next && w_got_next;
    wire rpdc_sel_t wr_sel = rpdc_decode(awaddr_next);
    wire wr_lane0 = wr_commit && wstrb0_next;
    wire pm_write = wr_lane0 && (wr_sel == RPDC_SEL_PM);
    wire ctrl_write = wr_lane0 && (wr_sel == RPDC_SEL_CTRL);

    always_comb begin
        wr_st_next = wr_st_reg;
        case (wr_st_reg)
            RPDC_CH_IDLE: begin
                if (wr_commit) begin
                    wr_st_next = RPDC_CH_RESP;
                end
            end
            RPDC_CH_RESP: begin
                if (s_axi_bready) begin
                    wr_st_next = RPDC_CH_IDLE;
                end
            end
            default: begin
                wr_st_next = RPDC_CH_IDLE;
            end
        endcase
    end

    assign bvalid_next = (wr_st_next == RPDC_CH_RESP);
    assign bresp_next = !wr_commit ? s_axi_bresp :
                        (wr_sel == RPDC_SEL_NONE) ? `RPDC_RESP_SLVERR : `RPDC_RESP_OKAY;
    assign awready_next = (wr_st_next == RPDC_CH_IDLE) && !aw_got_next;
    assign wready_next = (wr_st_next == RPDC_CH_IDLE) && !w_got_next;

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    rpdc_ch_st_t rd_st_reg, rd_st_next;
    logic [31:0] rdata_next;
    logic [1:0] rresp_next;

    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire rpdc_sel_t rd_sel = rpdc_decode(s_axi_araddr);

    always_comb begin
        rd_st_next = rd_st_reg;
        case (rd_st_reg)
            RPDC_CH_IDLE: begin
                if (ar_fire) begin
                    rd_st_next = RPDC_CH_RESP;
                end
            end
            RPDC_CH_RESP: begin
                if (s_axi_rready) begin
                    rd_st_next = RPDC_CH_IDLE;
                end
            end
            default: begin
                rd_st_next = RPDC_CH_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic pm_full_reg, pm_full_next;
    logic pm_reg_pd_reg, pm_reg_pd_next;
    logic [1:0] ctrl_reg, ctrl_next;

    // A set in the alarm cycle wins; zero writes never clear a power-down
    assign pm_full_next = (pm_full_reg && !alarm_sync) ||
                          (pm_write && wdata_next[`RPDC_PM_FULL_BIT]);
    assign pm_reg_pd_next = (pm_reg_pd_reg && !alarm_sync) ||
                            (pm_write && wdata_next[`RPDC_PM_REG_BIT]);
    assign ctrl_next = ctrl_write ? wdata_next[1:0] : ctrl_reg;

    // Reserved bits are not stored, so they read zero whatever was written
    wire [31:0] pm_view = {29'h0, pm_full_reg, pm_reg_pd_reg, 1'b0};
    wire [31:0] ctrl_view = {30'h0, ctrl_reg};
    assign rdata_next = !ar_fire ? s_axi_rdata :
                        (rd_sel == RPDC_SEL_PM) ? pm_view :
                        (rd_sel == RPDC_SEL_CTRL) ? ctrl_view : 32'h0;
    assign rresp_next = !ar_fire ? s_axi_rresp :
                        (rd_sel == RPDC_SEL_NONE) ? `RPDC_RESP_SLVERR : `RPDC_RESP_OKAY;

    // Enables come from next values so a write lands at its own edge
    wire pd_any_next = pm_full_next || pm_reg_pd_next;
    rpdc_supply_t supply_next;
    assign supply_next.bandgap_en = !pm_full_next;
    assign supply_next.por_en = !pd_any_next;
    assign supply_next.analog_regulator_en = !pd_any_next;
    assign supply_next.core_regulator_en = !pd_any_next;
    assign supply_next.usb_regulator_en = !pd_any_next && ctrl_next[`RPDC_CTRL_USB_BIT];
    assign supply_next.core_voltage_select = ctrl_next[`RPDC_CTRL_VSEL_BIT];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pm_full_reg <= 1'b0;
            pm_reg_pd_reg <= 1'b0;
            ctrl_reg <= `RPDC_CTRL_RESET;
            supply_o <= `RPDC_SUPPLY_RESET;
        end else if (ce_i) begin
            pm_full_reg <= pm_full_next;
            pm_reg_pd_reg <= pm_reg_pd_next;
            ctrl_reg <= ctrl_next;
            supply_o <= supply_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_st_reg <= RPDC_CH_IDLE;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 16'h0;
            wdata_reg <= 32'h0;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RPDC_RESP_OKAY;
        end else if (ce_i) begin
            wr_st_reg <= wr_st_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            s_axi_awready <= awready_next;
            s_axi_wready <= wready_next;
            s_axi_bvalid <= bvalid_next;
            s_axi_bresp <= bresp_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_st_reg <= RPDC_CH_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RPDC_RESP_OKAY;
        end else if (ce_i) begin
            rd_st_reg <= rd_st_next;
            s_axi_arready <= (rd_st_next == RPDC_CH_IDLE);
            s_axi_rvalid <= (rd_st_next == RPDC_CH_RESP);
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wire pd_any = pm_full_reg || pm_reg_pd_reg;

    property p_full_down;
        pm_full_reg |-> !supply_o.bandgap_en && !supply_o.por_en &&
            !supply_o.core_regulator_en && !supply_o.usb_regulator_en;
    endproperty
    a_full_down: assert property (p_full_down) else $error("full power-down leaks");

    property p_reg_down;
        (pm_reg_pd_reg && !pm_full_reg) |-> supply_o.bandgap_en &&
            !supply_o.analog_regulator_en && !supply_o.por_en;
    endproperty
    a_reg_down: assert property (p_reg_down) else $error("regulator power-down wrong");

    property p_alarm_wake;
        (ce_i && alarm_sync && !pm_write) |=> !pd_any ##0 supply_o.por_en;
    endproperty
    a_alarm_wake: assert property (p_alarm_wake) else $error("alarm did not wake");

    property p_reserved_zero;
        s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_vsel_write;
        (ce_i && ctrl_write) |=> supply_o.core_voltage_select == $past(wdata_next[1]);
    endproperty
    a_vsel_write: assert property (p_vsel_write) else $error("voltage select late");

    property p_usb_switch;
        !pd_any |-> supply_o.usb_regulator_en == ctrl_reg[`RPDC_CTRL_USB_BIT];
    endproperty
    a_usb_switch: assert property (p_usb_switch) else $error("usb enable mismatch");

    property p_sticky_down;
        (pd_any && !alarm_sync) |=> pd_any;
    endproperty
    a_sticky_down: assert property (p_sticky_down) else $error("power-down cleared");

    property p_pm_set;
        (ce_i && pm_write && wdata_next[2]) |=> pm_full_reg ##1 pm_full_reg || $past(alarm_sync);
    endproperty
    a_pm_set: assert property (p_pm_set) else $error("power-down bit not set");

    property p_bresp_hold;
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");

    c_full_down: cover property (pm_full_reg ##[1:20] !pm_full_reg);
    c_reg_down: cover property (pm_reg_pd_reg && !pm_full_reg);
    c_usb_on: cover property (supply_o.usb_regulator_en && supply_o.core_voltage_select);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `RPDC_RESP_SLVERR);

endmodule : rpdc_top

// ---- rpdc_defines.svh ----
`ifndef RPDC_DEFINES_SVH
`define RPDC_DEFINES_SVH

// Register byte addresses
`define RPDC_ADDR_PM 16'h1930
`define RPDC_ADDR_CTRL 16'h7004

// Power-management register fields
`define RPDC_PM_FULL_BIT 2
`define RPDC_PM_REG_BIT 1
`define RPDC_PM_RESET 2'h0

// Regulator control register fields
`define RPDC_CTRL_VSEL_BIT 1
`define RPDC_CTRL_USB_BIT 0
`define RPDC_CTRL_RESET 2'h0

// Supply enables out of reset: bandgap, reset circuit, analog and core on; usb off; 1.3 V
`define RPDC_SUPPLY_RESET 6'h3c

// AXI responses
`define RPDC_RESP_OKAY 2'h0
`define RPDC_RESP_SLVERR 2'h2

`endif

// ---- rpdc_pkg.sv ----
package rpdc_pkg;

    // Enables towards the analog supply blocks
    typedef struct packed {
        logic bandgap_en;
        logic por_en;
        logic analog_regulator_en;
        logic core_regulator_en;
        logic usb_regulator_en;
        logic core_voltage_select;
    } rpdc_supply_t;

    typedef enum logic [1:0] {
        RPDC_SEL_NONE = 2'b00,
        RPDC_SEL_PM = 2'b01,
        RPDC_SEL_CTRL = 2'b10
    } rpdc_sel_t;

    typedef enum logic [1:0] {
        RPDC_CH_IDLE = 2'b00,
        RPDC_CH_RESP = 2'b01
    } rpdc_ch_st_t;

endpackage : rpdc_pkg

// ---- rpdc_sync.sv ----
`timescale 1ns/1ps

module rpdc_sync (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Asynchronous level in, synchronised level out
    input wire logic async_i,
    output logic sync_o
);

    logic meta_reg;
    logic sync_reg;

    // The first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (ce_i) begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : rpdc_sync

// ---- regulator_power_down_control_bench.sv ----
`timescale 1ns/1ps
`include "rpdc_defines.svh"
module regulator_power_down_control_bench;
    import rpdc_pkg::*;
    logic clk_i, rst_n_i, ce_i, rtc_alarm_i;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    rpdc_supply_t supply_o;
    logic m_full, m_reg, m_vsel, m_usb;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    rpdc_top i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .rtc_alarm_i(rtc_alarm_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .supply_o(supply_o)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Power-down gates usb as well, so the usb switch alone never wakes anything
    function automatic logic [5:0] exp_supply();
        logic off;
        off = m_full | m_reg;
        return {~m_full, ~off, ~off, ~off, m_usb & ~off, m_vsel};
    endfunction : exp_supply

    task automatic chk_sup(input string nm);
        chk(nm, {26'h0, supply_o}, {26'h0, exp_supply()});
    endtask : chk_sup

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] er;
        er = `RPDC_RESP_OKAY;
        if (a == `RPDC_ADDR_PM && s[0]) begin
            m_full = m_full | d[`RPDC_PM_FULL_BIT];
            m_reg = m_reg | d[`RPDC_PM_REG_BIT];
        end else if (a == `RPDC_ADDR_CTRL && s[0]) begin
            m_vsel = d[`RPDC_CTRL_VSEL_BIT];
            m_usb = d[`RPDC_CTRL_USB_BIT];
        end else if (a != `RPDC_ADDR_PM && a != `RPDC_ADDR_CTRL) begin
            er = `RPDC_RESP_SLVERR;
        end
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        chk_sup("supply_wr");
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [15:0] a);
        logic [31:0] ed;
        logic [1:0] er;
        ed = 32'h0;
        er = `RPDC_RESP_OKAY;
        if (a == `RPDC_ADDR_PM) ed = {29'h0, m_full, m_reg, 1'b0};
        else if (a == `RPDC_ADDR_CTRL) ed = {30'h0, m_vsel, m_usb};
        else er = `RPDC_RESP_SLVERR;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clk_i);
    endtask : rd

    // Alarm passes two sync flops, so supplies return at the third edge after it rises
    task automatic alarm();
        rtc_alarm_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_sup("supply_early");
        @(posedge clk_i);
        m_full = 1'b0;
        m_reg = 1'b0;
        chk_sup("supply_wake");
        rtc_alarm_i <= 1'b0;
        // Stand-in for the bandgap settling wait before software goes on
        repeat (4) @(posedge clk_i);
    endtask : alarm

    function automatic logic [15:0] pick();
        logic [1:0] k;
        logic [15:0] u;
        k = 2'($urandom_range(2));
        u = 16'($urandom) & 16'hfffc;
        if (u == `RPDC_ADDR_PM || u == `RPDC_ADDR_CTRL) u = u ^ 16'h0100;
        return (k == 2'h0) ? `RPDC_ADDR_PM : (k == 2'h1) ? `RPDC_ADDR_CTRL : u;
    endfunction : pick
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        logic [15:0] a;
        logic [31:0] d;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        rtc_alarm_i = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {m_full, m_reg, m_vsel, m_usb} = 4'h0;
        void'($urandom(32'h7eee));
        repeat (20) @(posedge clk_i);
        chk_sup("supply_rst");
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(`RPDC_ADDR_PM);
        rd(`RPDC_ADDR_CTRL);
        rd(16'h1934);
        wr(16'h1934, 32'hffff_ffff, 4'hf);
        wr(`RPDC_ADDR_CTRL, 32'hffff_fffe, 4'hf);
        wr(`RPDC_ADDR_CTRL, 32'h0000_0001, 4'hf);
        wr(`RPDC_ADDR_CTRL, 32'h0000_0002, 4'he);
        rd(`RPDC_ADDR_CTRL);
        // Regulators are never bypassed here, so power-down is always allowed
        wr(`RPDC_ADDR_PM, 32'h0000_0002, 4'h1);
        wr(`RPDC_ADDR_PM, 32'h0000_0000, 4'h1);
        wr(`RPDC_ADDR_CTRL, 32'h0000_0003, 4'h1);
        wr(`RPDC_ADDR_PM, 32'h0000_0004, 4'h1);
        rd(`RPDC_ADDR_PM);
        alarm();
        wr(`RPDC_ADDR_PM, 32'h0000_0004, 4'h1);
        // An alarm during a low clock enable is never seen and wakes nothing
        ce_i <= 1'b0;
        rtc_alarm_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk_sup("supply_frozen");
        ce_i <= 1'b1;
        rtc_alarm_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_sup("supply_thawed");
        alarm();
        for (int i = 0; i < 60; i++) begin
            a = pick();
            d = $urandom;
            // Reserved low bits of the power register are kept at their default
            if (a == `RPDC_ADDR_PM) d = d & 32'hffff_ffe6;
            wr(a, d, 4'($urandom));
            rd(pick());
            if (i % 6 == 5) alarm();
        end
        summarize();
    end
endmodule : regulator_power_down_control_bench
